// *** pkg/mrlu_params.svh ***
`ifndef MRLU_PARAMS_SVH
`define MRLU_PARAMS_SVH
// Mask and vector widths
`define MRLU_MASK_W 64
`define MRLU_VEC_W 512
`define MRLU_SHAMT_W 8
// Width select codes
`define MRLU_WID_8 2'h0
`define MRLU_WID_16 2'h1
`define MRLU_WID_32 2'h2
`define MRLU_WID_64 2'h3
// Flag bit positions in the status flag word
`define MRLU_FLAG_CF 0
`define MRLU_FLAG_PF 2
`define MRLU_FLAG_AF 4
`define MRLU_FLAG_ZF 6
`define MRLU_FLAG_SF 7
`define MRLU_FLAG_OF 11
`define MRLU_FLAGS_W 12
// Reset values
`define MRLU_MASK_RST 64'h0
`define MRLU_FLAGS_RST 12'h000
// Result latency in cycles
`define MRLU_LATENCY 1
`endif

// *** pkg/mrlu_pkg.sv ***
`include "mrlu_params.svh"
package mrlu_pkg;
  typedef enum logic [4:0] {
    MRLU_OP_NOP = 5'h00,
    MRLU_OP_SUM = 5'h01,
    MRLU_OP_AND = 5'h02,
    MRLU_OP_ANDN = 5'h03,
    MRLU_OP_OR = 5'h04,
    MRLU_OP_XOR = 5'h05,
    MRLU_OP_XNOR = 5'h06,
    MRLU_OP_INV = 5'h07,
    MRLU_OP_SHL = 5'h08,
    MRLU_OP_SHR = 5'h09,
    MRLU_OP_JOIN = 5'h0a,
    MRLU_OP_MOVE = 5'h0b,
    MRLU_OP_ORTEST = 5'h0c,
    MRLU_OP_TEST = 5'h0d,
    MRLU_OP_VAND = 5'h0e,
    MRLU_OP_VNAND = 5'h0f,
    MRLU_OP_EXPAND = 5'h10,
    MRLU_OP_PACK = 5'h11,
    MRLU_OP_BCAST = 5'h12,
    MRLU_OP_WSEL = 5'h13
  } mrlu_op_e;
  typedef logic [1:0] mrlu_wid_t;
  // Issued operation
  typedef struct packed {
    logic valid;
    mrlu_op_e op;
    mrlu_wid_t wid;
    logic [`MRLU_SHAMT_W-1:0] count;
    logic [`MRLU_MASK_W-1:0] mask_a;
    logic [`MRLU_MASK_W-1:0] mask_b;
    logic [`MRLU_VEC_W-1:0] vec_a;
    logic [`MRLU_VEC_W-1:0] vec_b;
  } mrlu_req_s;
  // Produced result
  typedef struct packed {
    logic valid;
    logic mask_we;
    logic vec_we;
    logic flags_we;
    logic [`MRLU_MASK_W-1:0] mask;
    logic [`MRLU_VEC_W-1:0] vec;
    logic [`MRLU_FLAGS_W-1:0] flags;
  } mrlu_rsp_s;
endpackage : mrlu_pkg

// *** verilog/mrlu_mask_logic.sv ***
`timescale 1ns/10ps
`include "mrlu_params.svh"
// Mask-to-mask operations, combinational
module mrlu_mask_logic #(
  parameter int MW = `MRLU_MASK_W
) (
  input wire mrlu_pkg::mrlu_op_e op_in,
  input wire mrlu_pkg::mrlu_wid_t wid_in,
  input wire logic [`MRLU_SHAMT_W-1:0] count_in,
  input wire logic [MW-1:0] a_in,
  input wire logic [MW-1:0] b_in,
  output logic [MW-1:0] res_out,
  output logic zero_out,
  output logic ones_out
);
  // Bits kept at a given width
  function automatic logic [MW-1:0] width_mask(input mrlu_pkg::mrlu_wid_t w);
    unique case (w)
      `MRLU_WID_8: width_mask = MW'(64'h00000000000000ff);
      `MRLU_WID_16: width_mask = MW'(64'h000000000000ffff);
      `MRLU_WID_32: width_mask = MW'(64'h00000000ffffffff);
      default: width_mask = MW'(64'hffffffffffffffff);
    endcase
  endfunction : width_mask

  logic [MW-1:0] wm;
  logic [MW-1:0] am;
  logic [MW-1:0] bm;
  logic [MW-1:0] raw;

  // Operation select and width trimming
  always_comb begin
    wm = width_mask(wid_in);
    am = a_in & wm;
    bm = b_in & wm;
    raw = '0;
    unique case (op_in)
      mrlu_pkg::MRLU_OP_SUM: raw = am + bm; // [RULE1]
      mrlu_pkg::MRLU_OP_AND: raw = am & bm; // [RULE2]
      mrlu_pkg::MRLU_OP_ANDN: raw = ~am & bm; // [RULE3]
      mrlu_pkg::MRLU_OP_OR: raw = am | bm; // [RULE4]
      mrlu_pkg::MRLU_OP_XOR: raw = am ^ bm; // [RULE5]
      mrlu_pkg::MRLU_OP_XNOR: raw = ~(am ^ bm); // [RULE6]
      mrlu_pkg::MRLU_OP_INV: raw = ~am; // [RULE7]
      mrlu_pkg::MRLU_OP_SHL: raw = (count_in >= 8'(MW)) ? '0 : am << count_in; // [RULE8]
      mrlu_pkg::MRLU_OP_SHR: raw = (count_in >= 8'(MW)) ? '0 : am >> count_in; // [RULE9]
      // Low half of b in low half, low half of a above it
      mrlu_pkg::MRLU_OP_JOIN: begin
        unique case (wid_in)
          `MRLU_WID_16: raw = MW'({a_in[7:0], b_in[7:0]}); // [RULE10]
          `MRLU_WID_32: raw = MW'({a_in[15:0], b_in[15:0]}); // [RULE10]
          `MRLU_WID_64: raw = MW'({a_in[31:0], b_in[31:0]}); // [RULE10]
          default: raw = MW'({a_in[3:0], b_in[3:0]});
        endcase
      end
      mrlu_pkg::MRLU_OP_MOVE: raw = am; // [RULE11]
      mrlu_pkg::MRLU_OP_ORTEST: raw = am | bm; // [RULE12]
      mrlu_pkg::MRLU_OP_TEST: raw = am & bm; // [RULE13]
      default: raw = '0;
    endcase
    res_out = raw & wm; // [RULE20]
    zero_out = (res_out == '0); // [RULE21]
    ones_out = (res_out == wm); // [RULE21]
  end
endmodule : mrlu_mask_logic

// *** verilog/mrlu_vec_logic.sv ***
`timescale 1ns/10ps
`include "mrlu_params.svh"
// Vector/mask conversions, combinational
module mrlu_vec_logic #(
  parameter int MW = `MRLU_MASK_W,
  parameter int VW = `MRLU_VEC_W
) (
  input wire mrlu_pkg::mrlu_op_e op_in,
  input wire mrlu_pkg::mrlu_wid_t wid_in,
  input wire logic [MW-1:0] mask_in,
  input wire logic [VW-1:0] a_in,
  input wire logic [VW-1:0] b_in,
  output logic [MW-1:0] mask_out,
  output logic [VW-1:0] vec_out
);
  logic [MW-1:0] nz8;
  logic [MW-1:0] msb8;
  logic [VW/16-1:0] nz16;
  logic [VW/16-1:0] msb16;
  logic [VW/32-1:0] nz32;
  logic [VW/32-1:0] msb32;
  logic [VW/64-1:0] nz64;
  logic [VW/64-1:0] msb64;
  logic [VW-1:0] ex8;
  logic [VW-1:0] ex16;
  logic [VW-1:0] ex32;
  logic [VW-1:0] ex64;
  logic [VW-1:0] wsel;
  logic [VW-1:0] andv;

  assign andv = a_in & b_in;

  // Per-element AND tests, sign bits and expansions
  genvar i;
  generate
    for (i = 0; i < VW / 8; i++) begin : g_b
      assign nz8[i] = |andv[i*8 +: 8]; // [RULE14]
      assign msb8[i] = a_in[i*8+7]; // [RULE17]
      assign ex8[i*8 +: 8] = {8{mask_in[i]}}; // [RULE16]
    end
    for (i = 0; i < VW / 16; i++) begin : g_w
      assign nz16[i] = |andv[i*16 +: 16];
      assign msb16[i] = a_in[i*16+15];
      assign ex16[i*16 +: 16] = {16{mask_in[i]}};
      assign wsel[i*16 +: 16] = mask_in[i] ? b_in[i*16 +: 16] : a_in[i*16 +: 16]; // [RULE19]
    end
    for (i = 0; i < VW / 32; i++) begin : g_d
      assign nz32[i] = |andv[i*32 +: 32];
      assign msb32[i] = a_in[i*32+31];
      assign ex32[i*32 +: 32] = {32{mask_in[i]}};
    end
    for (i = 0; i < VW / 64; i++) begin : g_q
      assign nz64[i] = |andv[i*64 +: 64];
      assign msb64[i] = a_in[i*64+63];
      assign ex64[i*64 +: 64] = {64{mask_in[i]}};
    end
  endgenerate

  // Width and operation select
  always_comb begin
    logic [MW-1:0] nz;
    logic [MW-1:0] msb;
    logic [VW-1:0] ex;
    nz = nz8;
    msb = msb8;
    ex = ex8;
    unique case (wid_in)
      `MRLU_WID_8: begin
        nz = nz8;
        msb = msb8;
        ex = ex8;
      end
      `MRLU_WID_16: begin
        nz = MW'(nz16);
        msb = MW'(msb16);
        ex = ex16;
      end
      `MRLU_WID_32: begin
        nz = MW'(nz32);
        msb = MW'(msb32);
        ex = ex32;
      end
      default: begin
        nz = MW'(nz64);
        msb = MW'(msb64);
        ex = ex64;
      end
    endcase
    mask_out = '0;
    unique case (op_in)
      mrlu_pkg::MRLU_OP_VAND: mask_out = nz; // [RULE14]
      mrlu_pkg::MRLU_OP_VNAND: mask_out = ~nz; // [RULE15]
      mrlu_pkg::MRLU_OP_PACK: mask_out = msb; // [RULE17]
      default: mask_out = '0;
    endcase
    // Element count limits the mask for elements wider than 8 bits
    if (wid_in != `MRLU_WID_8)
      mask_out = mask_out & MW'((65'h1 << (VW / (8 << wid_in))) - 65'h1);
    vec_out = ex;
    unique case (op_in)
      mrlu_pkg::MRLU_OP_EXPAND: vec_out = ex; // [RULE16]
      mrlu_pkg::MRLU_OP_BCAST: vec_out = {(VW/MW){mask_in}}; // [RULE18]
      mrlu_pkg::MRLU_OP_WSEL: vec_out = wsel; // [RULE19]
      default: vec_out = ex;
    endcase
  end
endmodule : mrlu_vec_logic

// *** verilog/mrlu_top.sv ***
`timescale 1ns/10ps
`include "mrlu_params.svh"
// Overview of operation
// [RULE1] Sum two masks at width 8, 16, 32 or 64 bits.
// [RULE2] AND two masks at the selected width.
// [RULE3] AND of inverted first mask with second mask.
// [RULE4] OR two masks at the selected width.
// [RULE5] XOR two masks at the selected width.
// [RULE6] XNOR two masks at the selected width.
// [RULE7] Invert a mask at the selected width.
// [RULE8] Shift mask left by instruction count, zero fill.
// [RULE9] Shift mask right by instruction count, zero fill.
// [RULE10] Join low halves of two masks into double-width mask.
// [RULE11] Move mask data between mask, general registers and memory. The unit only copies the first mask at the selected width.
// [RULE12] OR two masks, no mask write, update status flags.
// [RULE13] Test two masks, no mask write, update status flags.
// [RULE14] Mask bit set when element pair AND is nonzero.
// [RULE15] Mask bit set when element pair AND is zero.
// [RULE16] Expand each mask bit into an all-ones or all-zeros element.
// [RULE17] Pack element sign bits into a mask.
// [RULE18] Replicate mask into every vector element.
// [RULE19] Select each word from two vectors by mask bit.
// [RULE20] Masks are 64 bits; bits above width are zeroed.
// [RULE21] Zero flag on all zeros, carry on all ones, others cleared.
module mrlu_top #(
  parameter int MW = `MRLU_MASK_W,
  parameter int VW = `MRLU_VEC_W
) (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  input wire mrlu_pkg::mrlu_req_s req_in,
  output mrlu_pkg::mrlu_rsp_s rsp_out
);
  logic [MW-1:0] mask_res;
  logic [VW-1:0] vec_res;
  logic [MW-1:0] vmask_res;
  logic res_zero;
  logic res_ones;
  mrlu_pkg::mrlu_rsp_s rsp;
  mrlu_pkg::mrlu_rsp_s next_rsp;

  mrlu_mask_logic #(
    .MW(MW)
  ) u_mask (
    .op_in(req_in.op),
    .wid_in(req_in.wid),
    .count_in(req_in.count),
    .a_in(req_in.mask_a),
    .b_in(req_in.mask_b),
    .res_out(mask_res),
    .zero_out(res_zero),
    .ones_out(res_ones)
  );

  mrlu_vec_logic #(
    .MW(MW),
    .VW(VW)
  ) u_vec (
    .op_in(req_in.op),
    .wid_in(req_in.wid),
    .mask_in(req_in.mask_a),
    .a_in(req_in.vec_a),
    .b_in(req_in.vec_b),
    .mask_out(vmask_res),
    .vec_out(vec_res)
  );

  // Result routing and write enables
  always_comb begin
    next_rsp = '0;
    next_rsp.valid = req_in.valid;
    if (req_in.valid) begin
      unique case (req_in.op)
        mrlu_pkg::MRLU_OP_ORTEST,
        mrlu_pkg::MRLU_OP_TEST: begin
          next_rsp.flags_we = 1'b1; // [RULE12] [RULE13]
          next_rsp.flags[`MRLU_FLAG_ZF] = res_zero; // [RULE21]
          next_rsp.flags[`MRLU_FLAG_CF] = res_ones; // [RULE21]
        end
        mrlu_pkg::MRLU_OP_VAND,
        mrlu_pkg::MRLU_OP_VNAND,
        mrlu_pkg::MRLU_OP_PACK: begin
          next_rsp.mask_we = 1'b1;
          next_rsp.mask = vmask_res; // [RULE14] [RULE15] [RULE17]
        end
        mrlu_pkg::MRLU_OP_EXPAND,
        mrlu_pkg::MRLU_OP_BCAST,
        mrlu_pkg::MRLU_OP_WSEL: begin
          next_rsp.vec_we = 1'b1;
          next_rsp.vec = vec_res; // [RULE16] [RULE18] [RULE19]
        end
        mrlu_pkg::MRLU_OP_NOP: next_rsp.mask_we = 1'b0;
        default: begin
          next_rsp.mask_we = 1'b1;
          next_rsp.mask = mask_res; // [RULE20]
        end
      endcase
    end
  end

  // Result register, cleared by reset even with the enable low, otherwise frozen while the enable is low
  always_ff @(posedge mclk_in) begin
    if (reset_in)
      rsp <= '0;
    else if (clk_en_in)
      rsp <= next_rsp;
  end

  assign rsp_out = rsp;
endmodule : mrlu_top

// *** verif/mrlu_top_checker.sv ***
`timescale 1ns/10ps
// Port-level checks on the mask unit
module mrlu_top_checker #(
  parameter int MW = 64,
  parameter int VW = 512
) (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  input wire mrlu_pkg::mrlu_req_s req_in,
  input wire mrlu_pkg::mrlu_rsp_s rsp_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (reset_in);
  logic g;
  logic [31:0] k;
  logic [63:0] a, b, m;
  // Taken request, one-hot by op code; k only at full width
  assign g = clk_en_in & req_in.valid;
  assign k = (g && req_in.wid == 2'h3) ? (32'h1 << req_in.op) : 32'h0;
  assign a = req_in.mask_a;
  assign b = req_in.mask_b;
  assign m = rsp_out.mask;
  chk_sum_op: assert property (k[1] |=> m == $past(a + b))
    else $error("sum wrong");
  chk_and_op: assert property (k[2] |=> m == $past(a & b))
    else $error("and wrong");
  chk_andn_op: assert property (k[3] |=> m == $past(~a & b))
    else $error("and inverted wrong");
  chk_xnor_op: assert property (k[6] |=> m == $past(~(a ^ b)))
    else $error("xnor wrong");
  chk_inv_op: assert property (k[7] |-> ##1 m == ~$past(a))
    else $error("invert wrong");
  chk_shl_op: assert property (k[8] |=> m == $past(a << req_in.count))
    else $error("shift left wrong");
  chk_shr_op: assert property (k[9] |=> m == $past(a >> req_in.count))
    else $error("shift right wrong");
  chk_narrow_trim: assert property (g && req_in.wid == 2'h0 && req_in.op inside
    {[mrlu_pkg::MRLU_OP_SUM:mrlu_pkg::MRLU_OP_MOVE]} |=> m[63:8] == 56'h0)
    else $error("bits above width");
  chk_ortest_flags: assert property (k[12] |=> rsp_out.flags ==
    {5'h0, $past(a | b) == 64'h0, 5'h0, &$past(a | b)})
    else $error("or test flags wrong");
  chk_test_nowrite: assert property (g && req_in.op == mrlu_pkg::MRLU_OP_TEST
    |-> ##1 rsp_out.flags_we && !rsp_out.mask_we)
    else $error("test wrote mask");
  cover property (k[12]);
  cover property (k[10]);
  cover property (!clk_en_in && rsp_out.valid);
endmodule : mrlu_top_checker
bind mrlu_top mrlu_top_checker #(.MW(MW), .VW(VW)) chk_i (.mclk_in(mclk_in),
  .reset_in(reset_in), .clk_en_in(clk_en_in), .req_in(req_in), .rsp_out(rsp_out));

// *** verif/mrlu_issue_model.sv ***
`timescale 1ns/10ps
// Decoder and vector file issuing to the unit
module mrlu_issue_model (
  input wire logic mclk_in,
  input wire mrlu_pkg::mrlu_req_s want_in,
  output mrlu_pkg::mrlu_req_s req_out
);
  mrlu_pkg::mrlu_req_s last;
  // Empty slot shows the inverted operands of the last slot
  always_comb begin
    if (want_in.valid) begin
      req_out = want_in;
    end else begin
      req_out = ~last;
      req_out.valid = 1'b0;
    end
  end
  // Last slot seen
  always_ff @(posedge mclk_in) begin
    last <= req_out;
  end
endmodule : mrlu_issue_model

// *** verif/test_mask_register_logic_unit.sv ***
`timescale 1ns/10ps
module test_mask_register_logic_unit;
  logic mclk_in = 1'b0;
  logic reset_in = 1'b1;
  logic clk_en_in = 1'b1;
  mrlu_pkg::mrlu_req_s want = '0;
  mrlu_pkg::mrlu_req_s req;
  mrlu_pkg::mrlu_rsp_s rsp;
  int failures = 0;
  int compares = 0;
  `define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin \
    failures++; $display("ERROR %0t value mismatch", $time); end end
  // Clock, 25 ns
  always #12.5 mclk_in = ~mclk_in;
  mrlu_issue_model partner (.mclk_in(mclk_in), .want_in(want), .req_out(req));
  mrlu_top uut (.mclk_in(mclk_in), .reset_in(reset_in), .clk_en_in(clk_en_in),
    .req_in(req), .rsp_out(rsp));
  // One op, result visible on return
  task automatic issue(input mrlu_pkg::mrlu_op_e op, input mrlu_pkg::mrlu_wid_t w,
      input logic [7:0] c, input logic [63:0] a, b, input logic [511:0] va, vb);
    @(posedge mclk_in);
    #1;
    want = {1'b1, op, w, c, a, b, va, vb};
    @(posedge mclk_in);
    #1;
    want.valid = 1'b0;
  endtask : issue
  // Expected mask result
  function automatic logic [63:0] exp_mask(input int op, input int w, input logic [7:0] c,
      input logic [63:0] a, b);
    logic [63:0] m, h;
    m = {64{1'b1}} >> (64 - (8 << w));
    h = m >> (4 << w);
    a = a & m;
    b = b & m;
    case (op)
      1: return (a + b) & m;
      2: return a & b;
      3: return ~a & b;
      4: return a | b;
      5: return a ^ b;
      6: return ~(a ^ b) & m;
      7: return ~a & m;
      8: return (a << c) & m;
      9: return a >> c;
      10: return ((a & h) << (4 << w)) | (b & h);
      default: return a;
    endcase
  endfunction : exp_mask
  // Mask ops SUM to MOVE at every width, shift counts within width
  task automatic t_mask_ops();
    logic [63:0] a, b, e;
    a = 64'hc3a5_96f0_0f69_5a3c;
    b = 64'h7e81_3cc3_f00f_a55a;
    for (int op = 1; op <= 11; op++) begin
      for (int w = 0; w < 4; w++) begin
        e = exp_mask(op, w, 8'(w * 9 + 1), a, b);
        issue(mrlu_pkg::mrlu_op_e'(op), w[1:0], 8'(w * 9 + 1), a, b, '0, '0);
        `CHK({rsp.mask_we, rsp.mask}, {1'b1, e})
        `CHK(rsp.mask, e)
      end
    end
  endtask : t_mask_ops
  // Flag updates, no mask write
  task automatic t_flags();
    issue(mrlu_pkg::MRLU_OP_ORTEST, 2'h3, 8'h0, {4{16'h0f0f}}, {4{16'hf0f0}}, '0, '0);
    `CHK({rsp.flags_we, rsp.mask_we, rsp.flags}, 14'h2001)
    issue(mrlu_pkg::MRLU_OP_ORTEST, 2'h1, 8'h0, 64'hffff_0000, 64'h0, '0, '0);
    `CHK({rsp.flags_we, rsp.mask_we, rsp.flags}, 14'h2040)
    issue(mrlu_pkg::MRLU_OP_TEST, 2'h1, 8'h0, 64'h0, '1, '0, '0);
    `CHK({rsp.flags_we, rsp.mask_we, rsp.flags}, 14'h2040)
  endtask : t_flags
  // Vector and mask conversions
  task automatic t_vectors();
    logic [511:0] v, e;
    v = 512'h10;
    // Element 0 nonzero at every element size, mask limited to element count
    for (int w = 0; w < 4; w++) begin
      issue(mrlu_pkg::MRLU_OP_VAND, w[1:0], 8'h0, '0, '0, '1, v);
      `CHK(rsp.mask, 64'h1)
      issue(mrlu_pkg::MRLU_OP_VNAND, w[1:0], 8'h0, '0, '0, '1, v);
      `CHK(rsp.mask, ({64{1'b1}} >> (64 - (64 >> w))) & ~64'h1)
    end
    for (int i = 0; i < 64; i++) v[i*8 +: 8] = i[0] ? 8'h7f : 8'h80;
    issue(mrlu_pkg::MRLU_OP_PACK, 2'h0, 8'h0, '0, '0, v, '0);
    `CHK(rsp.mask, {4{16'h5555}})
    e = {{320{1'b0}}, {64{1'b1}}, 64'h0, {64{1'b1}}};
    issue(mrlu_pkg::MRLU_OP_EXPAND, 2'h3, 8'h0, 64'h5, '0, '0, '0);
    `CHK({rsp.vec_we, rsp.vec}, {1'b1, e})
    issue(mrlu_pkg::MRLU_OP_EXPAND, 2'h0, 8'h0, 64'h5, '0, '0, '0);
    `CHK(rsp.vec, 512'hff00ff)
    e = v;
    e[31:16] = 16'h0;
    issue(mrlu_pkg::MRLU_OP_WSEL, 2'h1, 8'h0, 64'h2, '0, v, '0);
    `CHK({rsp.vec_we, rsp.vec}, {1'b1, e})
    issue(mrlu_pkg::MRLU_OP_BCAST, 2'h3, 8'h0, 64'h5, '0, '0, '0);
    `CHK({rsp.vec_we, rsp.vec}, {1'b1, {8{64'h5}}})
  endtask : t_vectors
  // Back to back ops, with a frozen cycle between their results
  task automatic t_hold();
    @(posedge mclk_in);
    #1;
    want = {1'b1, mrlu_pkg::MRLU_OP_AND, 2'h3, 8'h0, 64'hf0, 64'h3c, 1024'h0};
    @(posedge mclk_in);
    #1;
    want.op = mrlu_pkg::MRLU_OP_OR;
    `CHK(rsp.mask, 64'h30)
    clk_en_in = 1'b0;
    @(posedge mclk_in);
    #1;
    `CHK(rsp.mask, 64'h30)
    clk_en_in = 1'b1;
    @(posedge mclk_in);
    #1;
    want.valid = 1'b0;
    `CHK(rsp.mask, 64'hfc)
  endtask : t_hold
  // Reset in mid-run clears a standing result, then empty and narrow ops
  task automatic t_reset();
    issue(mrlu_pkg::MRLU_OP_OR, 2'h3, 8'h0, 64'h0f, 64'hf0, '0, '0);
    `CHK(rsp.mask, 64'hff)
    reset_in = 1'b1;
    repeat (2) @(posedge mclk_in);
    #1;
    `CHK(rsp, mrlu_pkg::mrlu_rsp_s'(0))
    reset_in = 1'b0;
    issue(mrlu_pkg::MRLU_OP_NOP, 2'h0, 8'h0, '0, '0, '0, '0);
    `CHK({rsp.valid, rsp.mask_we, rsp.vec_we, rsp.flags_we}, 4'h8)
    issue(mrlu_pkg::MRLU_OP_XOR, 2'h0, 8'h0, 64'h1ff, 64'h0f, '0, '0);
    `CHK(rsp.mask, 64'hf0)
  endtask : t_reset
  // Verdict
  task automatic final_report();
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report
  // Main sequence
  initial begin
    repeat (5) @(posedge mclk_in);
    #1;
    reset_in = 1'b0;
    `CHK(rsp, mrlu_pkg::mrlu_rsp_s'(0))
    t_mask_ops();
    t_flags();
    t_vectors();
    t_hold();
    t_reset();
    final_report();
  end
  // Watchdog
  initial begin
    #20us;
    failures++;
    final_report();
  end
endmodule : test_mask_register_logic_unit
